// ==== hw/usbdcs_top.sv ====
/*
 * usbdcs_top: usb device control and setup block: endpoint interrupt
 * enables, function enable, fifo visibility, remote wakeup and setup
 * byte readback, with a sticky event status and one interrupt line.
 * assumes: the serial engine, fifos and transceiver sit outside and are
 * synchronous to clk_sys; the cpu drives the plain register port.
 */
// The address-and-strobe port was decided locally.
// Function
// - Bits 0 to 4 of the out fifo enable register gate each endpoint's out fifo interrupt.
// - An in token to an endpoint with an empty in fifo is answered with a nak.
// - The nak enable register resets to zero and gates each endpoint's in fifo nak interrupt.
// - After system reset the control register is zero and the function is disabled.
// - A usb bus reset does not change the enable bit.
// - Clearing then setting the enable bit reinitialises part of the engine and some status bits.
// - With the visibility bit set the selected endpoint fifo appears in external data space.
// - With the wakeup bit set the device drives the resume k state on the data lines.
// - The wakeup bit never sets the resume-seen flag.
// - A setup packet's eight bytes are stored, keeping the latest packet.
// - A 3-bit index in bits 2:0, reset to zero, selects which setup byte is read.
// - Reading the value register returns the setup byte at the index.
`timescale 1ns/1ps
module usbdcs_top #(
   parameter int unsigned NUM_EP = usbdcs_pkg::NUM_EP
) (
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rstn,
   // register port
   input  wire logic [7:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [7:0]        reg_rdata,
   // serial engine events
   input  wire logic              usb_bus_reset,
   input  wire logic              host_resume,
   input  wire logic [NUM_EP-1:0] ep_out_done,
   input  wire logic [NUM_EP-1:0] ep_in_empty,
   input  wire logic              in_token,
   input  wire logic [2:0]        token_ep,
   // setup packet bytes
   input  wire logic              setup_start,
   input  wire logic              setup_valid,
   input  wire logic [7:0]        setup_data,
   // serial engine control
   output logic                   serial_engine_on,
   output logic                   serial_engine_init,
   output logic                   in_nak_send,
   output logic                   resume_k_drive,
   output logic                   fifo_visible,
   // fifo interrupt requests and the event interrupt
   output logic [NUM_EP-1:0]      ep_out_irq,
   output logic [NUM_EP-1:0]      ep_in_nak_irq,
   output logic                   irq
);
   // =====================================================================
   // decode
   // =====================================================================
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   logic wr_out_en;
   logic wr_nak_en;
   logic wr_ctl;
   logic wr_idx;
   logic wr_sts;
   logic wr_msk;

   assign wr_out_en = reg_wr && hit(reg_addr, usbdcs_pkg::OFS_OUT_IRQ_EN);
   assign wr_nak_en = reg_wr && hit(reg_addr, usbdcs_pkg::OFS_IN_NAK_EN);
   assign wr_ctl    = reg_wr && hit(reg_addr, usbdcs_pkg::OFS_FUNC_CTRL);
   assign wr_idx    = reg_wr && hit(reg_addr, usbdcs_pkg::OFS_SETUP_IDX);
   assign wr_sts    = reg_wr && hit(reg_addr, usbdcs_pkg::OFS_EVT_STATUS);
   assign wr_msk    = reg_wr && hit(reg_addr, usbdcs_pkg::OFS_EVT_MASK);

   // =====================================================================
   // registers
   // =====================================================================
   logic [7:0] out_fifo_irq_enable_r;
   logic [7:0] in_nak_irq_enable_r;
   logic [7:0] usb_function_control_r;
   logic [7:0] setup_byte_index_r;
   logic [7:0] evt_status_r;
   logic [7:0] evt_mask_r;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         out_fifo_irq_enable_r <= usbdcs_pkg::RST_VAL;
      end else if (wr_out_en) begin
         out_fifo_irq_enable_r <= reg_wdata & usbdcs_pkg::EP_MASK;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         in_nak_irq_enable_r <= usbdcs_pkg::RST_VAL;
      end else if (wr_nak_en) begin
         in_nak_irq_enable_r <= reg_wdata & usbdcs_pkg::EP_MASK;
      end
   end

   // bus reset deliberately absent: only software or rstn touch this
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         usb_function_control_r <= usbdcs_pkg::RST_VAL;
      end else if (wr_ctl) begin
         usb_function_control_r <= reg_wdata & usbdcs_pkg::CTL_MASK;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         setup_byte_index_r <= usbdcs_pkg::RST_VAL;
      end else if (wr_idx) begin
         setup_byte_index_r <= reg_wdata & usbdcs_pkg::IDX_MASK;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         evt_mask_r <= usbdcs_pkg::RST_VAL;
      end else if (wr_msk) begin
         evt_mask_r <= reg_wdata & usbdcs_pkg::EVT_MASK;
      end
   end

   logic func_en;
   assign func_en      = usb_function_control_r[usbdcs_pkg::CTL_ENABLE];
   assign fifo_visible = usb_function_control_r[usbdcs_pkg::CTL_VISIBLE];

   // =====================================================================
   // enable transitions
   // =====================================================================
   // a disable/enable cycle holds the engine in init for a short gap so the
   // external engine and its status bits see a clean restart
   localparam int unsigned GAP_W = $clog2(usbdcs_pkg::ENA_GAP_CYC + 1);
   logic             func_en_d_r;
   logic [GAP_W-1:0] init_cnt_r;
   logic [GAP_W-1:0] init_cnt_nxt;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         func_en_d_r <= 1'b0;
      end else begin
         func_en_d_r <= func_en;
      end
   end

   always_comb begin
      init_cnt_nxt = init_cnt_r;
      if (!func_en) begin
         init_cnt_nxt = GAP_W'(usbdcs_pkg::ENA_GAP_CYC);
      end else if (init_cnt_r != '0) begin
         init_cnt_nxt = init_cnt_r - GAP_W'(1);
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         init_cnt_r <= GAP_W'(usbdcs_pkg::ENA_GAP_CYC);
      end else begin
         init_cnt_r <= init_cnt_nxt;
      end
   end

   assign serial_engine_init = (init_cnt_r != '0);
   assign serial_engine_on   = func_en && func_en_d_r && !serial_engine_init;

   // =====================================================================
   // wakeup
   // =====================================================================
   // duration is the cpu's job; the block drives k for as long as the bit stands
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         resume_k_drive <= 1'b0;
      end else begin
         resume_k_drive <= usb_function_control_r[usbdcs_pkg::CTL_WAKEUP];
      end
   end

   // =====================================================================
   // token handling
   // =====================================================================
   logic [NUM_EP-1:0] tok_sel;
   logic              nak_now;

   always_comb begin
      tok_sel = '0;
      for (int i = 0; i < NUM_EP; i++) begin
         tok_sel[i] = (token_ep == 3'(i));
      end
   end

   // tokens are dropped entirely while the engine is off
   assign nak_now = serial_engine_on && in_token && |(tok_sel & ep_in_empty);

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         in_nak_send <= 1'b0;
      end else begin
         in_nak_send <= nak_now;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ep_in_nak_irq <= '0;
         ep_out_irq    <= '0;
      end else begin
         ep_in_nak_irq <= {NUM_EP{nak_now}} & tok_sel & in_nak_irq_enable_r[NUM_EP-1:0];
         ep_out_irq    <= {NUM_EP{serial_engine_on}} & ep_out_done
                          & out_fifo_irq_enable_r[NUM_EP-1:0];
      end
   end

   // =====================================================================
   // setup buffer
   // =====================================================================
   logic       setup_done;
   logic [7:0] setup_rd;

   usbdcs_setup_buf #(
      .DEPTH (usbdcs_pkg::SETUP_BYTES),
      .IDX_W (usbdcs_pkg::IDX_W)
   ) u_setup (
      .clk_sys  (clk_sys),
      .rstn     (rstn),
      .wr_start (setup_start && serial_engine_on),
      .wr_valid (setup_valid && serial_engine_on),
      .wr_data  (setup_data),
      .wr_done  (setup_done),
      .rd_idx   (setup_byte_index_r[usbdcs_pkg::IDX_W-1:0]),
      .rd_data  (setup_rd)
   );

   // =====================================================================
   // event status
   // =====================================================================
   logic [7:0] evt_set;

   always_comb begin
      evt_set = '0;
      evt_set[NUM_EP-1:0]           = ep_out_irq | ep_in_nak_irq;
      evt_set[usbdcs_pkg::EVT_SETUP]  = setup_done;
      // only host resume feeds this flag, never our own wakeup drive
      evt_set[usbdcs_pkg::EVT_RESUME] = host_resume && !resume_k_drive;
   end

   // set wins over a write-one clear in the same cycle
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         evt_status_r <= usbdcs_pkg::RST_VAL;
      end else begin
         evt_status_r <= ((wr_sts ? evt_status_r & ~reg_wdata : evt_status_r) | evt_set)
                         & usbdcs_pkg::EVT_MASK;
      end
   end

   assign irq = |(evt_status_r & evt_mask_r);

   // =====================================================================
   // read port
   // =====================================================================
   logic [7:0] rd_mux;

   always_comb begin
      case (reg_addr)
         usbdcs_pkg::OFS_OUT_IRQ_EN: rd_mux = out_fifo_irq_enable_r;
         usbdcs_pkg::OFS_IN_NAK_EN:  rd_mux = in_nak_irq_enable_r;
         usbdcs_pkg::OFS_FUNC_CTRL:  rd_mux = usb_function_control_r;
         usbdcs_pkg::OFS_SETUP_IDX:  rd_mux = setup_byte_index_r;
         usbdcs_pkg::OFS_SETUP_VAL:  rd_mux = setup_rd;
         usbdcs_pkg::OFS_EVT_STATUS: rd_mux = evt_status_r;
         usbdcs_pkg::OFS_EVT_MASK:   rd_mux = evt_mask_r;
         default:                    rd_mux = 8'h_00;
      endcase
   end

   // data stands only in the cycle after the strobe
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 8'h_00;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 8'h_00;
      end
   end

   logic unused_bus_reset;
   assign unused_bus_reset = usb_bus_reset;
endmodule

// ==== hw/usbdcs_pkg.sv ====
/*
 * usbdcs_pkg: register offsets, field positions, reset values and timing
 * constants for the usb device control and setup block.
 * assumes: a byte-wide register port addressed by 8-bit offsets.
 */
package usbdcs_pkg;
   // =====================================================================
   // geometry
   // =====================================================================
   localparam int unsigned NUM_EP      = 5;
   localparam int unsigned SETUP_BYTES = 8;
   localparam int unsigned IDX_W       = 3;

   // =====================================================================
   // register offsets
   // =====================================================================
   localparam logic [7:0] OFS_OUT_IRQ_EN  = 8'h_e6;
   localparam logic [7:0] OFS_IN_NAK_EN   = 8'h_e7;
   localparam logic [7:0] OFS_FUNC_CTRL   = 8'h_ec;
   localparam logic [7:0] OFS_SETUP_IDX   = 8'h_f5;
   localparam logic [7:0] OFS_SETUP_VAL   = 8'h_f6;
   localparam logic [7:0] OFS_EVT_STATUS  = 8'h_d0;
   localparam logic [7:0] OFS_EVT_MASK    = 8'h_d1;

   // =====================================================================
   // control fields and reset values
   // =====================================================================
   localparam int unsigned CTL_WAKEUP  = 0;
   localparam int unsigned CTL_VISIBLE = 1;
   localparam int unsigned CTL_ENABLE  = 2;
   localparam logic [7:0]  CTL_MASK    = 8'h_07;
   localparam logic [7:0]  EP_MASK     = 8'h_1f;
   localparam logic [7:0]  IDX_MASK    = 8'h_07;
   localparam logic [7:0]  RST_VAL     = 8'h_00;

   // event status bits: [4:0] ep out or in nak, [5] setup stored, [6] host resume
   localparam int unsigned EVT_SETUP   = 5;
   localparam int unsigned EVT_RESUME  = 6;
   localparam logic [7:0]  EVT_MASK    = 8'h_7f;

   // =====================================================================
   // timing
   // =====================================================================
   localparam int unsigned CLK_MHZ     = 100;
   localparam int unsigned ENA_GAP_NS  = 20;
   localparam int unsigned ENA_GAP_CYC = (ENA_GAP_NS * CLK_MHZ + 999) / 1000;
endpackage

// ==== hw/usbdcs_setup_buf.sv ====
/*
 * usbdcs_setup_buf: eight-byte buffer of the latest setup packet.
 * assumes: the serial engine delivers bytes in order with a start pulse
 * marking byte 0 of each packet.
 */
`timescale 1ns/1ps
module usbdcs_setup_buf #(
   parameter int unsigned DEPTH = 8,
   parameter int unsigned IDX_W = 3
) (
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rstn,
   // write side from the serial engine
   input  wire logic             wr_start,
   input  wire logic             wr_valid,
   input  wire logic [7:0]       wr_data,
   output logic                  wr_done,
   // read side
   input  wire logic [IDX_W-1:0] rd_idx,
   output logic      [7:0]       rd_data
);
   logic [7:0]       mem_r [DEPTH];
   logic [IDX_W-1:0] wptr_r;
   logic [IDX_W-1:0] wsel;

   // start pulse resets the pointer so a torn packet never shifts bytes
   assign wsel = wr_start ? '0 : wptr_r;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wptr_r <= '0;
      end else if (wr_valid) begin
         wptr_r <= wsel + IDX_W'(1);
      end else if (wr_start) begin
         wptr_r <= '0;
      end
   end

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_byte
         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               mem_r[g] <= 8'h_00;
            end else if (wr_valid && wsel == IDX_W'(g)) begin
               mem_r[g] <= wr_data;
            end
         end
      end
   endgenerate

   assign wr_done = wr_valid && (wsel == IDX_W'(DEPTH - 1));
   assign rd_data = mem_r[rd_idx];
endmodule

// ==== tb/usbdcs_assertions.sv ====
/* port checker for usbdcs_top.
   assumes: bound below to every usbdcs_top instance. */
`timescale 1ns/1ps
module usbdcs_assertions #(
   parameter int unsigned NUM_EP = 5
) (
   // clock and reset
   input wire logic              clk_sys,
   input wire logic              rstn,
   // register port
   input wire logic [7:0]        reg_addr,
   input wire logic [7:0]        reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [7:0]        reg_rdata,
   // engine side
   input wire logic              usb_bus_reset,
   input wire logic [NUM_EP-1:0] ep_out_done,
   input wire logic [NUM_EP-1:0] ep_in_empty,
   input wire logic              in_token,
   input wire logic [2:0]        token_ep,
   input wire logic              serial_engine_on,
   input wire logic              serial_engine_init,
   input wire logic              in_nak_send,
   input wire logic              resume_k_drive,
   input wire logic              fifo_visible,
   input wire logic [NUM_EP-1:0] ep_out_irq,
   input wire logic [NUM_EP-1:0] ep_in_nak_irq
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   wire ctl_wr = reg_wr && reg_addr == 8'h_ec;
   property p_nak;
      in_token && serial_engine_on && token_ep < 3'h_5 && ep_in_empty[token_ep] |=> in_nak_send;
   endproperty
   a_nak: assert property (p_nak) else $error("nak missing");
   property p_off;
      in_token && !serial_engine_on |=> !in_nak_send;
   endproperty
   a_off: assert property (p_off) else $error("token answered while off");
   property p_rst;
      $rose(rstn) |-> serial_engine_init && !serial_engine_on && !resume_k_drive && !fifo_visible;
   endproperty
   a_rst: assert property (p_rst) else $error("not idle after reset");
   property p_vis;
      ctl_wr |=> fifo_visible == $past(reg_wdata[1]);
   endproperty
   a_vis: assert property (p_vis) else $error("visibility wrong");
   property p_wake;
      ctl_wr && reg_wdata[0] |-> ##2 resume_k_drive;
   endproperty
   a_wake: assert property (p_wake) else $error("k state missing");
   property p_busrst;
      usb_bus_reset && serial_engine_on && !ctl_wr |=> serial_engine_on;
   endproperty
   a_busrst: assert property (p_busrst) else $error("bus reset disabled");
   property p_reinit;
      ctl_wr && !reg_wdata[2] |=> !serial_engine_on ##1 serial_engine_init && !serial_engine_on;
   endproperty
   a_reinit: assert property (p_reinit) else $error("engine not reset");
   property p_outirq;
      ep_out_irq != '0 |-> $past(serial_engine_on) && (ep_out_irq & ~$past(ep_out_done)) == '0;
   endproperty
   a_outirq: assert property (p_outirq) else $error("out irq uncaused");
   property p_nakirq;
      ep_in_nak_irq != '0 |-> in_nak_send && ep_in_nak_irq == NUM_EP'(1) << $past(token_ep);
   endproperty
   a_nakirq: assert property (p_nakirq) else $error("nak irq wrong");
   property p_rsv;
      reg_rd && reg_addr inside {8'h_e6, 8'h_e7} |=> reg_rdata[7:5] == 3'h_0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
   property p_idx;
      reg_rd && reg_addr == 8'h_f5 |=> reg_rdata[7:3] == 5'h_00;
   endproperty
   a_idx: assert property (p_idx) else $error("index too wide");
   c_nak: cover property (in_nak_send);
   c_wake: cover property (resume_k_drive);
   c_off: cover property (in_token && !serial_engine_on);
endmodule
bind usbdcs_top usbdcs_assertions #(.NUM_EP(NUM_EP)) u_chk (.clk_sys, .rstn, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .usb_bus_reset, .ep_out_done, .ep_in_empty, .in_token, .token_ep,
   .serial_engine_on, .serial_engine_init, .in_nak_send, .resume_k_drive, .fifo_visible,
   .ep_out_irq, .ep_in_nak_irq);

// ==== tb/usbdcs_host_model.sv ====
/* behavioural serial engine side: tokens, setup bytes, host resume.
   assumes: tasks are called from the bench, one at a time. */
`timescale 1ns/1ps
module usbdcs_host_model (
   // clock
   input wire logic  clk_sys,
   // token side
   output logic       in_token,
   output logic [2:0] token_ep,
   output logic [4:0] ep_in_empty,
   output logic       host_resume,
   // setup bytes
   output logic       setup_start,
   output logic       setup_valid,
   output logic [7:0] setup_data
);
   initial begin
      in_token = 1'b0;
      token_ep = 3'h_0;
      ep_in_empty = 5'h_1f;
      host_resume = 1'b0;
      setup_start = 1'b0;
      setup_valid = 1'b0;
      setup_data = 8'h_00;
   end
   task automatic set_empty(input logic [4:0] m);
      @(posedge clk_sys);
      ep_in_empty <= m;
   endtask
   task automatic send_in(input logic [2:0] ep);
      @(posedge clk_sys);
      in_token <= 1'b1;
      token_ep <= ep;
      @(posedge clk_sys);
      in_token <= 1'b0;
      token_ep <= ~ep; // idle lines never keep the last endpoint
   endtask
   task automatic send_setup(input logic [63:0] pkt);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_sys);
         setup_start <= (i == 0);
         setup_valid <= 1'b1;
         setup_data <= pkt[8*i +: 8];
      end
      @(posedge clk_sys);
      setup_start <= 1'b0;
      setup_valid <= 1'b0;
      setup_data <= ~pkt[63:56];
   endtask
   task automatic resume_pulse;
      @(posedge clk_sys);
      host_resume <= 1'b1;
      @(posedge clk_sys);
      host_resume <= 1'b0;
   endtask
endmodule

// ==== tb/usbdcs_top_tb.sv ====
/* self-checking bench for usbdcs_top.
   assumes: host model drives tokens, setup bytes and resume, bench the register port, usb_bus_reset and ep_out_done. */
`timescale 1ns/1ps
module usbdcs_top_tb;
   logic clk_sys, rstn, reg_wr, reg_rd, usb_bus_reset, in_token, host_resume;
   logic setup_start, setup_valid, serial_engine_on, serial_engine_init;
   logic in_nak_send, resume_k_drive, fifo_visible, irq, rd_seen;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, setup_data, v;
   logic [4:0] ep_out_done, ep_in_empty, ep_out_irq, ep_in_nak_irq;
   logic [2:0] token_ep;
   logic [31:0] lfsr_r;
   logic [63:0] pkt;
   logic [7:0] exp_q[$];
   logic [7:0] ofs[4] = '{8'h_e6, 8'h_e7, 8'h_ec, 8'h_f5};
   logic [7:0] msk[4] = '{8'h_1f, 8'h_1f, 8'h_07, 8'h_07};
   int num_errors, comparisons, nak_seen;
   usbdcs_top dut (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .usb_bus_reset,
      .host_resume, .ep_out_done, .ep_in_empty, .in_token, .token_ep, .setup_start, .setup_valid,
      .setup_data, .serial_engine_on, .serial_engine_init, .in_nak_send, .resume_k_drive,
      .fifo_visible, .ep_out_irq, .ep_in_nak_irq, .irq);
   usbdcs_host_model host (.clk_sys, .in_token, .token_ep, .ep_in_empty, .host_resume,
      .setup_start, .setup_valid, .setup_data);
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(e);
      @(posedge clk_sys);
      reg_rd <= 1'b0;
   endtask
   task automatic settle;
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // =====================================================================
   // read data watcher: one note per read strobe
   // =====================================================================
   always @(posedge clk_sys) rd_seen <= reg_rd;
   always @(negedge clk_sys) begin
      if (rd_seen === 1'b1) check("reg_rdata", reg_rdata, exp_q.pop_front());
      if (in_nak_send === 1'b1) nak_seen++;
   end
   // run is about 270 cycles; generous margin
   initial begin
      repeat (20000) @(posedge clk_sys);
      num_errors++;
      give_verdict();
   end
   initial begin
      {rstn, reg_wr, reg_rd, usb_bus_reset, reg_addr, reg_wdata, ep_out_done} = '0;
      {num_errors, comparisons, nak_seen} = '0;
      lfsr_r = 32'h_bbce_45e4;
      repeat (16) @(posedge clk_sys);
      rstn <= 1'b1;
      foreach (ofs[i]) rd(ofs[i], 8'h_00);
      rd(8'h_55, 8'h_00);
      check("engine_on", {7'h_00, serial_engine_on}, 8'h_00);
      $display("test reset done");
      for (int k = 0; k < 2; k++) begin
         lfsr_r = lfsr_next(lfsr_r);
         v = (k == 0) ? 8'h_ff : lfsr_r[7:0];
         foreach (ofs[i]) wr(ofs[i], v);
         foreach (ofs[i]) rd(ofs[i], v & msk[i]);
      end
      wr(8'h_f6, 8'h_ff);
      rd(8'h_f6, 8'h_00);
      $display("test fields done");
      wr(8'h_ec, 8'h_04);
      settle();
      check("engine_on", {7'h_00, serial_engine_on}, 8'h_01);
      usb_bus_reset <= 1'b1;
      settle();
      usb_bus_reset <= 1'b0;
      check("on after bus reset", {7'h_00, serial_engine_on}, 8'h_01);
      wr(8'h_ec, 8'h_00);
      // init count reloads one edge after the control write lands
      @(posedge clk_sys);
      @(negedge clk_sys);
      check("init", {6'h_00, serial_engine_init, serial_engine_on}, 8'h_02);
      wr(8'h_ec, 8'h_04);
      settle();
      $display("test enable done");
      for (int p = 0; p < 2; p++) begin
         lfsr_r = lfsr_next(lfsr_r);
         pkt[31:0] = lfsr_r;
         lfsr_r = lfsr_next(lfsr_r);
         pkt[63:32] = lfsr_r;
         host.send_setup(pkt);
         for (int i = 7; i >= 0; i--) begin
            wr(8'h_f5, 8'(i));
            rd(8'h_f5, 8'(i));
            rd(8'h_f6, pkt[8*i +: 8]);
         end
      end
      $display("test setup done");
      wr(8'h_d0, 8'h_7f);
      wr(8'h_d1, 8'h_7f);
      wr(8'h_e7, 8'h_05);
      host.set_empty(5'h_1b);
      for (int e = 0; e < 5; e++) host.send_in(3'(e));
      rd(8'h_d0, 8'h_01);
      check("irq", {7'h_00, irq}, 8'h_01);
      wr(8'h_d1, 8'h_00);
      @(negedge clk_sys);
      check("irq masked", {7'h_00, irq}, 8'h_00);
      wr(8'h_d1, 8'h_7f);
      wr(8'h_d0, 8'h_01);
      rd(8'h_d0, 8'h_00);
      wr(8'h_ec, 8'h_00);
      host.send_in(3'h_0);
      wr(8'h_ec, 8'h_04);
      settle();
      check("nak count", nak_seen[7:0], 8'h_04);
      $display("test nak done");
      wr(8'h_e6, 8'h_02);
      ep_out_done <= 5'h_03;
      @(posedge clk_sys);
      ep_out_done <= 5'h_00;
      rd(8'h_d0, 8'h_02);
      wr(8'h_d0, 8'h_7f);
      wr(8'h_ec, 8'h_07);
      settle();
      check("wake vis", {6'h_00, resume_k_drive, fifo_visible}, 8'h_03);
      rd(8'h_d0, 8'h_00);
      wr(8'h_ec, 8'h_04);
      settle();
      host.resume_pulse();
      rd(8'h_d0, 8'h_40);
      settle();
      $display("test wake done");
      give_verdict();
   end
endmodule
